// ==== src/sod_pkg.sv ====
//==============================================================================
//==============================================================================
`default_nettype none
package sod_pkg;
	// Timing.
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CHECK_PERIOD_MS = 10;
	localparam int unsigned CHECK_CYCLES = CLK_HZ / 1000 * CHECK_PERIOD_MS;
	localparam int unsigned PULSE_MAX_PPS = 500_000;
	// Register byte offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_THRESH = 8'h04;
	localparam logic [7:0] A_NUM = 8'h08;
	localparam logic [7:0] A_DEN = 8'h0C;
	localparam logic [7:0] A_LEN = 8'h10;
	localparam logic [7:0] A_CMD = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_LOGPOS = 8'h1C;
	localparam logic [7:0] A_ENCPOS = 8'h20;
	localparam logic [7:0] A_IRQ_ST = 8'h24;
	localparam logic [7:0] A_IRQ_CLR = 8'h28;
	localparam logic [7:0] A_IRQ_EN = 8'h2C;
	localparam logic [7:0] A_SLOT0 = 8'h30;
	localparam logic [7:0] A_SLOT3 = 8'h3C;
	// Field positions.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_WHILE_BIT = 1;
	localparam int CMD_DIR_BIT = 2;
	localparam int CMD_HOME_BIT = 3;
	localparam int CMD_RESET_BIT = 4;
	localparam int CMD_START_BIT = 5;
	localparam int SLOT_MODE_LSB = 20;
	localparam int IRQ_STEPOUT = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_REFUSED = 2;
	// Reset values.
	localparam logic [15:0] THRESH_RST = 16'h0064;
	localparam logic [15:0] NUM_RST = 16'h03E8;
	localparam logic [15:0] DEN_RST = 16'h00C8;
	localparam logic [18:0] SPEED_RST = 19'h0_03E8;
	localparam logic [1:0] MODE_CONST = 2'h0;
	// Controller states.
	typedef enum logic [2:0] {
		SOD_IDLE = 3'b001,
		SOD_MOVE = 3'b010,
		SOD_ERR = 3'b100
	} sod_state_e;
	// Keeps a 16-bit setting inside 1..65535.
	function automatic logic [15:0] sod_clamp16(input logic [15:0] v);
		sod_clamp16 = (v == 16'h0000) ? 16'h0001 : v;
	endfunction : sod_clamp16
	// Keeps a rate inside 1..500000 pulses per second.
	function automatic logic [18:0] sod_clamp_pps(input logic [18:0] v);
		if (v == 19'h0_0000)
			sod_clamp_pps = 19'h0_0001;
		else if (v > 19'(PULSE_MAX_PPS))
			sod_clamp_pps = 19'(PULSE_MAX_PPS);
		else
			sod_clamp_pps = v;
	endfunction : sod_clamp_pps
endpackage : sod_pkg
`default_nettype wire

// ==== src/sod_quad.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Quadrature counter
module sod_quad (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Encoder and control.
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic clear,
	// Count.
	output logic signed [31:0] count
);
	typedef struct packed {
		logic [1:0] prev;
		logic signed [31:0] cnt;
	} sod_quad_s;
	sod_quad_s s, n;

	// Every edge on one channel alone moves the count by one; a change on both at once is ignored.
	always_comb
	begin
		n = s;
		n.prev = {enc_a, enc_b};
		case ({s.prev, enc_a, enc_b})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: n.cnt = s.cnt + 32'sd1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: n.cnt = s.cnt - 32'sd1;
			default: n.cnt = s.cnt;
		endcase
		if (clear)
			n.cnt = 32'sd0;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else if (ce)
			s <= n;
	end

	assign count = s.cnt;

	chk_quad_step: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !clear |=> (s.cnt - $past(s.cnt)) inside {-1, 0, 1})
		else $error("Encoder count moved by more than one.");
endmodule : sod_quad
`default_nettype wire

// ==== src/sod_pulse_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Rate generator
module sod_pulse_gen (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Control.
	input wire logic run,
	input wire logic [18:0] pps,
	// One-cycle pulse at the programmed rate.
	output logic tick
);
	localparam logic [25:0] WRAP = 26'(sod_pkg::CLK_HZ);
	typedef struct packed {
		logic [25:0] acc;
	} sod_pulse_s;
	sod_pulse_s s, n;
	logic [25:0] sum;

	// Phase accumulator adds the rate each cycle and wraps at the clock rate.
	always_comb
	begin
		n = s;
		sum = s.acc + 26'(pps);
		tick = 1'b0;
		if (!run)
			n.acc = '0;
		else if (sum >= WRAP)
		begin
			n.acc = sum - WRAP;
			tick = 1'b1;
		end
		else
			n.acc = sum;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else if (ce)
			s <= n;
	end
endmodule : sod_pulse_gen
`default_nettype wire

// ==== src/sod_top.sv ====
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Step-out supervisor with constant-speed pulse output
module sod_top #(
	parameter int unsigned CHECK_CYCLES = sod_pkg::CHECK_CYCLES
) (
	// Clock, reset and enable.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Encoder.
	input wire logic enc_a,
	input wire logic enc_b,
	// Motor drive and status.
	output logic step_o,
	output logic dir_o,
	output logic err_o,
	output logic irq_o
);
	typedef struct packed {
		sod_pkg::sod_state_e state;
		logic ctrl_en;
		logic ctrl_while;
		logic [15:0] thresh;
		logic [15:0] num;
		logic [15:0] den;
		logic [3:0][21:0] slot;
		logic [31:0] len;
		logic [31:0] remain;
		logic signed [31:0] logpos;
		logic [1:0] sel;
		logic dir;
		logic home;
		logic [31:0] tick_cnt;
		logic check_req;
		logic enc_clr;
		logic [2:0] irq_st;
		logic [2:0] irq_en;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic step;
		logic irq;
	} sod_top_s;

	sod_top_s s, n;
	logic tick;
	logic signed [31:0] enc_cnt;
	logic signed [49:0] diff;
	logic [49:0] mag;
	logic [49:0] lim;
	logic over;
	logic addr_ok;
	logic cfg_ok;
	logic [2:0] set;
	logic [2:0] clr;
	logic [21:0] cur;

	//==========================================================================
	// Submodules
	sod_quad u_quad (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.clear(s.enc_clr),
		.count(enc_cnt)
	);

	sod_pulse_gen u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.run(s.state == sod_pkg::SOD_MOVE),
		.pps(s.slot[s.sel][18:0]),
		.tick(tick)
	);

	//==========================================================================
	// Step-out comparison
	// Cross-multiplied so no divider is needed: logical position times
	// denominator against encoder count times numerator, limit times
	// denominator. The threshold is raw drive pulses.
	always_comb
	begin
		diff = 50'(s.logpos * $signed({1'b0, s.den}))
			- 50'(enc_cnt * $signed({1'b0, s.num}));
		mag = diff[49] ? 50'(-diff) : 50'(diff);
		lim = 50'(s.thresh * s.den);
		over = mag > lim;
	end

	//==========================================================================
	// Next-state logic
	always_comb
	begin
		n = s;
		set = '0;
		clr = '0;
		n.step = 1'b0;
		n.check_req = 1'b0;
		n.enc_clr = 1'b0;
		cur = s.slot[hwdata[1:0]];
		cfg_ok = s.state != sod_pkg::SOD_ERR;
		addr_ok = hsel && htrans[1] && hready;
		// Address phase: capture write target, or fetch read data.
		n.wr_pend = addr_ok && hwrite;
		n.wr_addr = haddr[7:0];
		if (addr_ok && !hwrite)
		begin
			case (haddr[7:0])
				sod_pkg::A_CTRL: n.hrdata = {30'h0, s.ctrl_while, s.ctrl_en};
				sod_pkg::A_THRESH: n.hrdata = {16'h0000, s.thresh};
				sod_pkg::A_NUM: n.hrdata = {16'h0000, s.num};
				sod_pkg::A_DEN: n.hrdata = {16'h0000, s.den};
				sod_pkg::A_LEN: n.hrdata = s.len;
				sod_pkg::A_STATUS: n.hrdata = {29'h0, s.home,
					s.state == sod_pkg::SOD_ERR, s.state == sod_pkg::SOD_MOVE};
				sod_pkg::A_LOGPOS: n.hrdata = s.logpos;
				sod_pkg::A_ENCPOS: n.hrdata = enc_cnt;
				sod_pkg::A_IRQ_ST: n.hrdata = {29'h0, s.irq_st};
				sod_pkg::A_IRQ_EN: n.hrdata = {29'h0, s.irq_en};
				default:
				begin
					if (haddr[7:0] >= sod_pkg::A_SLOT0
						&& haddr[7:0] <= sod_pkg::A_SLOT3 && haddr[1:0] == 2'b00)
						n.hrdata = {10'h000, s.slot[haddr[3:2]]};
					else
						n.hrdata = 32'h0000_0000;
				end
			endcase
		end
		// Data phase of a write; configuration other than the interrupt enables is locked while in error.
		if (s.wr_pend)
		begin
			case (s.wr_addr)
				sod_pkg::A_CTRL:
				begin
					if (cfg_ok)
					begin
						n.ctrl_en = hwdata[sod_pkg::CTRL_EN_BIT];
						n.ctrl_while = hwdata[sod_pkg::CTRL_WHILE_BIT];
					end
				end
				sod_pkg::A_THRESH:
					if (cfg_ok)
						n.thresh = sod_pkg::sod_clamp16(hwdata[15:0]);
				sod_pkg::A_NUM:
					if (cfg_ok)
						n.num = sod_pkg::sod_clamp16(hwdata[15:0]);
				sod_pkg::A_DEN:
					if (cfg_ok)
						n.den = sod_pkg::sod_clamp16(hwdata[15:0]);
				sod_pkg::A_LEN:
					if (cfg_ok)
						n.len = hwdata;
				sod_pkg::A_IRQ_CLR: clr = hwdata[2:0];
				sod_pkg::A_IRQ_EN: n.irq_en = hwdata[2:0];
				sod_pkg::A_CMD:
				begin
					if (hwdata[sod_pkg::CMD_RESET_BIT])
					begin
						// Controller reset: drop the error, zero positions.
						n.state = sod_pkg::SOD_IDLE;
						n.logpos = 32'sd0;
						n.enc_clr = 1'b1;
						n.remain = 32'h0000_0000;
					end
					else if (hwdata[sod_pkg::CMD_START_BIT]
						|| hwdata[sod_pkg::CMD_HOME_BIT])
					begin
						if (s.state == sod_pkg::SOD_IDLE && s.len != 32'h0
							&& cur[21:20] == sod_pkg::MODE_CONST)
						begin
							n.state = sod_pkg::SOD_MOVE;
							n.remain = s.len;
							n.sel = hwdata[1:0];
							n.dir = hwdata[sod_pkg::CMD_DIR_BIT];
							n.home = hwdata[sod_pkg::CMD_HOME_BIT];
							n.tick_cnt = 32'h0000_0000;
						end
						else
							set[sod_pkg::IRQ_REFUSED] = 1'b1;
					end
				end
				default:
				begin
					if (cfg_ok && s.wr_addr >= sod_pkg::A_SLOT0
						&& s.wr_addr <= sod_pkg::A_SLOT3 && s.wr_addr[1:0] == 2'b00)
						n.slot[s.wr_addr[3:2]] = {hwdata[21:20], 1'b0,
							sod_pkg::sod_clamp_pps(hwdata[18:0])};
				end
			endcase
		end
		// Pulse issue during a move.
		if (s.state == sod_pkg::SOD_MOVE && tick)
		begin
			n.step = 1'b1;
			n.logpos = s.dir ? s.logpos - 32'sd1 : s.logpos + 32'sd1;
			n.remain = s.remain - 32'h0000_0001;
			if (s.remain == 32'h0000_0001)
			begin
				n.state = sod_pkg::SOD_IDLE;
				set[sod_pkg::IRQ_DONE] = 1'b1;
				if (s.home)
				begin
					n.logpos = 32'sd0;
					n.enc_clr = 1'b1;
				end
				else if (s.ctrl_en && !s.ctrl_while)
					n.check_req = 1'b1;
			end
		end
		// Periodic check while the motor turns, never during home search.
		if (s.state == sod_pkg::SOD_MOVE)
		begin
			if (s.tick_cnt >= CHECK_CYCLES - 1)
			begin
				n.tick_cnt = 32'h0000_0000;
				if (s.ctrl_en && s.ctrl_while && !s.home)
					n.check_req = 1'b1;
			end
			else
				n.tick_cnt = s.tick_cnt + 32'h0000_0001;
		end
		// A failed check latches the error and stops pulses at once.
		if (s.check_req && s.state != sod_pkg::SOD_ERR && over)
		begin
			n.state = sod_pkg::SOD_ERR;
			n.step = 1'b0;
			n.check_req = 1'b0;
			set[sod_pkg::IRQ_STEPOUT] = 1'b1;
		end
		// Sticky interrupt bits: a new event beats a clear.
		n.irq_st = (s.irq_st & ~clr) | set;
		n.irq = |(n.irq_st & n.irq_en);
	end

	//==========================================================================
	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s <= '0;
			s.state <= sod_pkg::SOD_IDLE;
			s.thresh <= sod_pkg::THRESH_RST;
			s.num <= sod_pkg::NUM_RST;
			s.den <= sod_pkg::DEN_RST;
			s.slot <= {4{3'b000, sod_pkg::SPEED_RST}};
			s.hreadyout <= 1'b1;
		end
		else if (ce)
			s <= n;
	end

	// Outputs straight from the state register.
	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp = 1'b0 & s.hreadyout;
	assign step_o = s.step;
	assign dir_o = s.dir;
	assign err_o = s.state[2]; // One-hot error bit.
	assign irq_o = s.irq;

	//==========================================================================
	// Checks
	chk_err_halts_motor: assert property (@(posedge hclk)
		disable iff (!hresetn) s.state == sod_pkg::SOD_ERR |=> !s.step)
		else $error("Pulse issued while in step-out error.");
	chk_err_has_cause: assert property (@(posedge hclk)
		disable iff (!hresetn) $rose(s.state == sod_pkg::SOD_ERR)
		|-> $past(s.check_req) && $past(over))
		else $error("Error raised without a failed check.");
	chk_scale_nonzero: assert property (@(posedge hclk)
		disable iff (!hresetn) s.num != 16'h0000 && s.den != 16'h0000)
		else $error("Encoder scale left the range 1..65535.");
	chk_thresh_nonzero: assert property (@(posedge hclk)
		disable iff (!hresetn) s.thresh != 16'h0000)
		else $error("Threshold left the range 1..65535.");
	chk_period_check: assert property (@(posedge hclk)
		disable iff (!hresetn) ce && s.state == sod_pkg::SOD_MOVE
		&& s.tick_cnt == CHECK_CYCLES - 1 && s.ctrl_en && s.ctrl_while
		&& !s.home |=> s.check_req)
		else $error("Periodic check missed.");
	chk_check_enabled: assert property (@(posedge hclk)
		disable iff (!hresetn) s.check_req |-> $past(s.ctrl_en))
		else $error("Check ran while disabled.");
	chk_home_quiet: assert property (@(posedge hclk)
		disable iff (!hresetn) s.check_req |-> !$past(s.home))
		else $error("Check ran during home search.");
	chk_cfg_locked: assert property (@(posedge hclk)
		disable iff (!hresetn) s.state == sod_pkg::SOD_ERR
		|=> $stable(s.thresh) && $stable(s.len) && $stable(s.ctrl_en))
		else $error("Configuration changed during error.");
	chk_err_latched: assert property (@(posedge hclk)
		disable iff (!hresetn) s.state == sod_pkg::SOD_ERR
		&& !(s.wr_pend && s.wr_addr == sod_pkg::A_CMD
		&& hwdata[sod_pkg::CMD_RESET_BIT]) |=> s.state == sod_pkg::SOD_ERR)
		else $error("Error cleared without reset.");
	chk_step_spacing: assert property (@(posedge hclk)
		disable iff (!hresetn) s.step && ce |=> !s.step)
		else $error("Pulses closer than the top rate allows.");
endmodule : sod_top
`default_nettype wire

// ==== testbench/sod_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Motor and encoder
module sod_motor_model (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Drive side.
	input wire logic step_o,
	input wire logic dir_o,
	input wire logic [15:0] skip,
	// Encoder side.
	output logic enc_a,
	output logic enc_b
);
	logic [1:0] ph;
	logic [15:0] lost;
	// Each step turns the shaft one quad edge, and lost steps leave it still.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph <= 2'h0;
			lost <= 16'h0000;
		end
		else if (step_o && lost < skip)
			lost <= lost + 16'h0001;
		else if (step_o)
			ph <= dir_o ? ph - 2'h1 : ph + 2'h1;
	end
	// Gray order puts B ahead of A on a plus move, which counts up.
	assign enc_a = ph[1];
	assign enc_b = ph[1] ^ ph[0];
endmodule : sod_motor_model
`default_nettype wire

// ==== testbench/step_out_detector_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Bench
module step_out_detector_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, enc_a, enc_b, step_o, dir_o, err_o, irq_o;
	logic [15:0] skip = 16'h0000;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int nstep = 0;
	int t_prev = 0;
	int t_last = 0;
	int seed = 89734;
	int rate[4] = '{500000, 250000, 400000, 200000};

	// Clock of 25 ns.
	always #12.5 hclk = ~hclk;

	sod_top #(.CHECK_CYCLES(50)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.enc_a(enc_a), .enc_b(enc_b), .step_o(step_o), .dir_o(dir_o),
		.err_o(err_o), .irq_o(irq_o));

	sod_motor_model mot_u (.hclk(hclk), .hresetn(hresetn), .step_o(step_o),
		.dir_o(dir_o), .skip(skip), .enc_a(enc_a), .enc_b(enc_b));

	// Counts drive pulses, times them and cuts a hang short.
	always @(posedge hclk)
	begin
		cyc++;
		if (step_o === 1'b1)
		begin
			nstep++;
			t_prev = t_last;
			t_last = cyc;
		end
		if (cyc == 60000)
		begin
			miscompares++;
			end_sim();
		end
	end

	// Compares one value with its expectation.
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One single AHB-Lite transfer; read data lands in rd.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Polls the moving flag until the move is over.
	task wait_idle();
		for (int i = 0; i < 3000; i++)
		begin
			bus(1'b0, sod_pkg::A_STATUS, 32'h0000_0000);
			if (rd[0] === 1'b0)
				break;
		end
		repeat (4) @(posedge hclk);
	endtask : wait_idle

	// Runs one move after raising the motor's lost-step limit skip by k.
	task move(input logic [1:0] sl, input logic dr, input int len, input int k);
		skip <= skip + 16'(k);
		bus(1'b1, sod_pkg::A_LEN, 32'(len));
		bus(1'b1, sod_pkg::A_CMD, {26'h000_0000, 3'h4, dr, sl});
		wait_idle();
	endtask : move

	// Controller reset command.
	task creset();
		bus(1'b1, sod_pkg::A_CMD, 32'h0000_0010);
		repeat (2) @(posedge hclk);
	endtask : creset

	// Nominal cycles between pulses at a rate.
	function automatic int per(input int r);
		return 40000000 / r;
	endfunction : per

	// Prints the counts and the verdict.
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// Main sequence.
	initial
	begin
		int n0, d, th, k;
		logic dr;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, sod_pkg::A_THRESH, 0);
		chk("thresh", rd, 32'h0000_0064);
		bus(1'b0, sod_pkg::A_NUM, 0);
		chk("num", rd, 32'h0000_03E8);
		bus(1'b0, sod_pkg::A_DEN, 0);
		chk("den", rd, 32'h0000_00C8);
		bus(1'b0, sod_pkg::A_CTRL, 0);
		chk("ctrl", rd, 32'h0000_0000);
		chk("hresp", hresp, 0);
		bus(1'b1, 8'h40, 32'h0000_FFFF);
		bus(1'b0, 8'h40, 0);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test reset values done");
		bus(1'b1, sod_pkg::A_NUM, 1);
		bus(1'b1, sod_pkg::A_DEN, 1);
		bus(1'b1, sod_pkg::A_IRQ_EN, 7);
		for (int i = 0; i < 4; i++)
			bus(1'b1, sod_pkg::A_SLOT0 + 8'(4 * i), 32'(rate[i]));
		for (int i = 0; i < 4; i++)
		begin
			n0 = nstep;
			move(2'(i), 1'b0, 3, 0);
			d = t_last - t_prev;
			chk("steps", nstep - n0, 3);
			chk("period", d >= per(rate[i]) - 1 && d <= per(rate[i]) + 1, 1);
		end
		bus(1'b1, sod_pkg::A_SLOT0 + 8'h0C, 32'h0010_0000 | rate[3]);
		n0 = nstep;
		move(2'h3, 1'b0, 3, 0);
		chk("mode", nstep - n0, 0);
		bus(1'b0, sod_pkg::A_IRQ_ST, 0);
		chk("refused", rd[2], 1);
		bus(1'b1, sod_pkg::A_IRQ_CLR, 7);
		$display("test slots done");
		for (int i = 0; i < 2; i++)
		begin
			creset();
			th = 2 + $unsigned($random(seed)) % 4;
			dr = 1'($random(seed));
			k = th - 2 + 3 * i; // Margin of two covers the encoder lag.
			bus(1'b1, sod_pkg::A_THRESH, 32'(th));
			bus(1'b1, sod_pkg::A_CTRL, 1);
			move(2'h0, dr, 12, k);
			chk("err", err_o, 32'(i));
			chk("dir", dir_o, dr);
			bus(1'b0, sod_pkg::A_ENCPOS, 0);
			chk("enc", rd, dr ? 32'(k - 12) : 32'(12 - k));
		end
		chk("irq", irq_o, 1);
		bus(1'b1, sod_pkg::A_IRQ_EN, 0);
		repeat (2) @(posedge hclk);
		chk("masked", irq_o, 0);
		bus(1'b1, sod_pkg::A_IRQ_EN, 7);
		bus(1'b1, sod_pkg::A_THRESH, 500);
		bus(1'b0, sod_pkg::A_THRESH, 0);
		chk("locked", rd, 32'(th));
		n0 = nstep;
		bus(1'b1, sod_pkg::A_CMD, 32'h0000_0020);
		repeat (200) @(posedge hclk);
		chk("no move", nstep - n0, 0);
		bus(1'b0, sod_pkg::A_IRQ_ST, 0);
		chk("refused", rd[2], 1);
		chk("latched", err_o, 1);
		bus(1'b1, sod_pkg::A_IRQ_CLR, 7);
		repeat (2) @(posedge hclk);
		chk("cleared", irq_o, 0);
		creset();
		chk("released", err_o, 0);
		$display("test drive end done");
		bus(1'b1, sod_pkg::A_THRESH, 2);
		bus(1'b1, sod_pkg::A_CTRL, 3);
		n0 = nstep;
		move(2'h0, 1'b0, 200, 200);
		chk("while", err_o, 1);
		chk("halted", nstep - n0 < 20, 1);
		// The reset pin also releases the error and reloads defaults.
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("pin release", err_o, 0);
		hresetn <= 1'b1;
		bus(1'b0, sod_pkg::A_THRESH, 0);
		chk("thresh again", rd, 32'h0000_0064);
		bus(1'b1, sod_pkg::A_NUM, 1);
		bus(1'b1, sod_pkg::A_DEN, 1);
		bus(1'b1, sod_pkg::A_THRESH, 2);
		bus(1'b1, sod_pkg::A_SLOT0, 32'(rate[0]));
		bus(1'b1, sod_pkg::A_CTRL, 0);
		move(2'h0, 1'b0, 10, 10);
		chk("disabled", err_o, 0);
		$display("test while drive done");
		creset();
		bus(1'b1, sod_pkg::A_CTRL, 3);
		skip <= skip + 16'h1000;
		bus(1'b1, sod_pkg::A_CMD, 32'h0000_0008);
		wait_idle();
		chk("home", err_o, 0);
		bus(1'b0, sod_pkg::A_LOGPOS, 0);
		chk("home pos", rd, 32'h0000_0000);
		$display("test home done");
		// Threshold of four times a step resolution of 20, all steps lost.
		bus(1'b1, sod_pkg::A_THRESH, 4 * 20);
		bus(1'b1, sod_pkg::A_CTRL, 1);
		move(2'h0, 1'b0, 80, 0);
		chk("margin", err_o, 0);
		move(2'h0, 1'b0, 1, 0);
		chk("beyond", err_o, 1);
		$display("test margin done");
		end_sim();
	end
endmodule : step_out_detector_tb
`default_nettype wire
